// ==== test/dcd_core_datapath_props.sv ====
`timescale 1ns/1ps
module dcd_props (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire dcd_pkg::dcd_op_t op_i,
    input wire logic [15:0] data_i,
    input wire logic [4:0] in_shift_i,
    input wire logic [2:0] out_shift_i,
    input wire logic out_high_i,
    input wire dcd_pkg::dcd_flow_t flow_i,
    input wire logic bus_ready_i,
    input wire logic [31:0] acc_o,
    input wire logic [31:0] prod_o,
    input wire logic [15:0] multiply_operand_reg_o,
    input wire logic [15:0] program_address_bus_o,
    input wire logic [15:0] next_addr_o,
    input wire logic [15:0] data_write_bus_o,
    input wire logic dwb_valid_o,
    input wire logic bit_result_o,
    input wire logic bit_valid_o
);
    function automatic logic [31:0] smul(logic [15:0] a, logic [15:0] b);
        logic signed [31:0] sa;
        logic signed [31:0] sb;
        sa = $signed(a);
        sb = $signed(b);
        return sa * sb;
    endfunction
    function automatic logic [15:0] ohalf(logic [31:0] a, logic [2:0] s,
                                          logic h);
        logic [31:0] w;
        w = a << s;
        return h ? w[31:16] : w[15:0];
    endfunction
    function automatic logic pick(logic [15:0] d, logic [15:0] t);
        return d[t[3:0]];
    endfunction
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    // Return must land one past the call site
    sequence call_then_ret;
        bus_ready_i && flow_i == dcd_pkg::FLOW_CALL
        ##1 bus_ready_i && flow_i == dcd_pkg::FLOW_RETURN;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_mul_signed: assert property (
        op_i == dcd_pkg::OP_MUL_SIGNED
        |=> prod_o == smul($past(multiply_operand_reg_o), $past(data_i)))
        else $error("signed product wrong");
    a_mul_unsigned: assert property (
        op_i == dcd_pkg::OP_MUL_UNSIGNED
        |=> prod_o == {16'h0000, $past(multiply_operand_reg_o)} * {16'h0000, $past(data_i)})
        else $error("unsigned product wrong");
    a_temp_load: assert property (
        op_i == dcd_pkg::OP_LOAD_TEMP |=> multiply_operand_reg_o == $past(data_i))
        else $error("temporary register not loaded");
    a_in_scale: assert property (
        op_i == dcd_pkg::OP_LOAD_SHIFTED && in_shift_i <= 5'h10
        |=> acc_o == ({16'h0000, $past(data_i)} << $past(in_shift_i)))
        else $error("input scaling wrong");
    a_out_scale: assert property (
        op_i == dcd_pkg::OP_STORE |=> dwb_valid_o && data_write_bus_o ==
        ohalf($past(acc_o), $past(out_shift_i), $past(out_high_i)))
        else $error("output scaling wrong");
    a_bit_test: assert property (
        op_i == dcd_pkg::OP_TEST_BIT_BY_TEMP
        |=> bit_valid_o && bit_result_o == pick($past(data_i), $past(multiply_operand_reg_o)))
        else $error("bit test wrong");
    a_add_scale: assert property (
        op_i == dcd_pkg::OP_ADD_SHIFTED && in_shift_i <= 5'h10
        |=> acc_o == $past(acc_o)
            + ({16'h0000, $past(data_i)} << $past(in_shift_i)))
        else $error("scaled add not done in one cycle");
    a_addr_hold: assert property (
        !bus_ready_i
        |=> $stable(program_address_bus_o) && $stable(next_addr_o))
        else $error("address moved while bus busy");
    a_addr_follow: assert property (
        bus_ready_i |=> program_address_bus_o == $past(next_addr_o))
        else $error("bus address not taken from next address");
    a_seq_step: assert property (
        bus_ready_i && flow_i == dcd_pkg::FLOW_SEQ
        |=> next_addr_o == $past(next_addr_o) + 16'h0001)
        else $error("sequential address not incremented");
    a_call_return: assert property (
        call_then_ret |=> next_addr_o == $past(next_addr_o, 2) + 16'h0001)
        else $error("return address wrong");
endmodule

bind dcd_core_datapath dcd_props u_dcd_props (
    .ref_clk_i, .srst_i, .op_i, .data_i, .in_shift_i, .out_shift_i,
    .out_high_i, .flow_i, .bus_ready_i, .acc_o, .prod_o, .multiply_operand_reg_o,
    .program_address_bus_o, .next_addr_o, .data_write_bus_o,
    .dwb_valid_o, .bit_result_o, .bit_valid_o
);

// ==== test/dcd_core_datapath_tb.sv ====
`timescale 1ns/1ps
module dcd_core_datapath_tb;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    dcd_pkg::dcd_op_t op_i = dcd_pkg::OP_NOP;
    logic [15:0] data_i = 16'h0000;
    logic [4:0] in_shift_i = 5'h00;
    dcd_pkg::dcd_product_scaler_t product_scaler_i = dcd_pkg::PRODUCT_SCALER_NONE;
    logic [2:0] out_shift_i = 3'h0;
    logic out_high_i = 1'b0;
    dcd_pkg::dcd_flow_t flow_i = dcd_pkg::FLOW_SEQ;
    dcd_pkg::dcd_cond_t cond_i = dcd_pkg::COND_ALWAYS;
    logic [15:0] target_i = 16'h0000;
    logic [15:0] push_data_i = 16'h0000;
    logic bus_ready_i = 1'b0;
    logic [31:0] acc_o;
    logic [31:0] prod_o;
    logic [15:0] multiply_operand_reg_o;
    logic [15:0] program_address_bus_o;
    logic [15:0] next_addr_o;
    logic [15:0] data_write_bus_o;
    logic [15:0] stack_top_o;
    logic [3:0] stack_depth_o;
    logic dwb_valid_o;
    logic bit_result_o;
    logic bit_valid_o;
    logic data_move_o;
    logic acc_zero_o;
    logic acc_neg_o;
    logic ovf_o;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    dcd_core_datapath u_dcd_core_datapath (
        .ref_clk_i, .srst_i, .op_i, .data_i, .in_shift_i, .product_scaler_i,
        .out_shift_i, .out_high_i, .flow_i, .cond_i, .target_i,
        .push_data_i, .bus_ready_i, .acc_o, .prod_o, .multiply_operand_reg_o,
        .program_address_bus_o, .next_addr_o, .data_write_bus_o,
        .dwb_valid_o, .bit_result_o, .bit_valid_o, .stack_top_o,
        .stack_depth_o, .data_move_o, .acc_zero_o, .acc_neg_o, .ovf_o
    );

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge so no sampling race arises
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk32(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic chk16(logic [15:0] got, logic [15:0] exp);
        chk32({16'h0000, got}, {16'h0000, exp});
    endtask
    task automatic op(dcd_pkg::dcd_op_t o, logic [15:0] d);
        op_i = o;
        data_i = d;
        tick();
    endtask
    // Leaves bus ready high; consecutive calls stay back to back
    task automatic flow(dcd_pkg::dcd_flow_t f, logic [15:0] t);
        flow_i = f;
        target_i = t;
        bus_ready_i = 1'b1;
        tick();
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_mult();
        op(dcd_pkg::OP_LOAD_TEMP, 16'hFFFD);
        chk16(multiply_operand_reg_o, 16'hFFFD);
        op(dcd_pkg::OP_MUL_SIGNED, 16'h0007);
        chk32(prod_o, 32'hFFFF_FFEB);
        op(dcd_pkg::OP_MUL_UNSIGNED, 16'hFFFF);
        chk32(prod_o, 32'hFFFC_0003);
        op(dcd_pkg::OP_LOAD_TEMP, 16'h8000);
        op(dcd_pkg::OP_MUL_SIGNED, 16'h8000);
        chk32(prod_o, 32'h4000_0000);
        $display("test mult done");
    endtask
    task automatic t_shift();
        for (int n = 0; n <= 16; n++) begin
            in_shift_i = 5'(n);
            op(dcd_pkg::OP_LOAD_SHIFTED, 16'h8001);
            chk32(acc_o, 32'h0000_8001 << n);
        end
        in_shift_i = 5'h04;
        op(dcd_pkg::OP_LOAD_SHIFTED, 16'hFFFF);
        chk32(acc_o, 32'h000F_FFF0);
        // Upper temp bits must not leak into the count
        op(dcd_pkg::OP_LOAD_TEMP, 16'h0015);
        op(dcd_pkg::OP_LOAD_SHIFTED_BY_TEMP, 16'h0003);
        chk32(acc_o, 32'h0000_0060);
        op(dcd_pkg::OP_ADD_SHIFTED_BY_TEMP, 16'h0001);
        chk32(acc_o, 32'h0000_0080);
        op(dcd_pkg::OP_SUB_SHIFTED_BY_TEMP, 16'h0002);
        chk32(acc_o, 32'h0000_0040);
        in_shift_i = 5'h10;
        op(dcd_pkg::OP_LOAD_SHIFTED, 16'h7FFF);
        op(dcd_pkg::OP_ADD_SHIFTED, 16'h7FFF);
        chk32(acc_o, 32'hFFFE_0000);
        chk16({15'h0000, ovf_o}, 16'h0001);
        $display("test shift done");
    endtask
    task automatic t_product_scaler();
        logic [31:0] exp [4];
        exp = '{32'hFFFF_FF00, 32'hFFFF_FE00, 32'hFFFF_F000, 32'hFFFF_FFFC};
        op(dcd_pkg::OP_LOAD_TEMP, 16'hFFFF);
        op(dcd_pkg::OP_MUL_SIGNED, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            product_scaler_i = dcd_pkg::dcd_product_scaler_t'(i);
            op(dcd_pkg::OP_LOAD_PROD, 16'h0000);
            chk32(acc_o, exp[i]);
        end
        op(dcd_pkg::OP_ADD_PROD, 16'h0000);
        chk32(acc_o, 32'hFFFF_FFF8);
        op(dcd_pkg::OP_SUB_PROD, 16'h0000);
        chk32(acc_o, 32'hFFFF_FFFC);
        chk16({15'h0000, acc_neg_o}, 16'h0001);
        op(dcd_pkg::OP_SUB_PROD, 16'h0000);
        chk32(acc_o, 32'h0000_0000);
        chk16({15'h0000, acc_zero_o}, 16'h0001);
        $display("test product_scaler done");
    endtask
    task automatic t_store();
        logic [31:0] w;
        in_shift_i = 5'h08;
        op(dcd_pkg::OP_LOAD_SHIFTED, 16'hA5C3);
        for (int s = 0; s < 16; s++) begin
            out_shift_i = 3'(s >> 1);
            out_high_i = s[0];
            w = 32'h00A5_C300 << (s >> 1);
            op(dcd_pkg::OP_STORE, 16'h0000);
            chk16(data_write_bus_o, s[0] ? w[31:16] : w[15:0]);
            chk16({15'h0000, dwb_valid_o}, 16'h0001);
        end
        op(dcd_pkg::OP_NOP, 16'h0000);
        chk16({15'h0000, dwb_valid_o}, 16'h0000);
        $display("test store done");
    endtask
    task automatic t_bit();
        logic [15:0] w;
        for (int i = 0; i < 16; i++) begin
            op(dcd_pkg::OP_LOAD_TEMP, 16'hFFF0 | 16'(i));
            op(dcd_pkg::OP_TEST_BIT_BY_TEMP, 16'h1234);
            w = (16'h1234 >> i) & 16'h0001;
            chk16({15'h0000, bit_result_o}, w);
            chk16({15'h0000, bit_valid_o}, 16'h0001);
        end
        op(dcd_pkg::OP_NOP, 16'h0000);
        chk16({15'h0000, bit_valid_o}, 16'h0000);
        $display("test bit done");
    endtask
    task automatic t_flow();
        chk16(program_address_bus_o, 16'h0000);
        flow(dcd_pkg::FLOW_SEQ, 16'h0000);
        chk16(next_addr_o, 16'h0001);
        flow(dcd_pkg::FLOW_CALL, 16'h0040);
        chk16(program_address_bus_o, 16'h0001);
        chk16(stack_top_o, 16'h0002);
        flow(dcd_pkg::FLOW_RETURN, 16'h0000);
        chk16(next_addr_o, 16'h0002);
        flow(dcd_pkg::FLOW_DATA_MOVE_START, 16'h0200);
        chk16({15'h0000, data_move_o}, 16'h0001);
        flow(dcd_pkg::FLOW_SEQ, 16'h0000);
        chk16(next_addr_o, 16'h0201);
        flow(dcd_pkg::FLOW_DATA_MOVE_END, 16'h0000);
        chk16(next_addr_o, 16'h0003);
        chk16({15'h0000, data_move_o}, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            push_data_i = 16'h1000 + 16'(i);
            flow(dcd_pkg::FLOW_PUSH, 16'h0000);
        end
        chk16({12'h000, stack_depth_o}, 16'h0008);
        repeat (7) flow(dcd_pkg::FLOW_POP, 16'h0000);
        chk16(stack_top_o, 16'h1001);
        repeat (2) flow(dcd_pkg::FLOW_POP, 16'h0000);
        chk16({12'h000, stack_depth_o}, 16'h0000);
        chk16(stack_top_o, 16'h1008);
        cond_i = dcd_pkg::COND_NEQ;
        flow(dcd_pkg::FLOW_BRANCH_COND, 16'h0300);
        chk16(next_addr_o, 16'h0300);
        cond_i = dcd_pkg::COND_EQ;
        flow(dcd_pkg::FLOW_BRANCH_COND, 16'h0500);
        chk16(next_addr_o, 16'h0301);
        bus_ready_i = 1'b0;
        flow_i = dcd_pkg::FLOW_BRANCH;
        repeat (3) tick();
        chk16(program_address_bus_o, 16'h0300);
        chk16(next_addr_o, 16'h0301);
        $display("test flow done");
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs about 125 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (6) tick();
        srst_i = 1'b0;
        t_mult();
        t_shift();
        t_product_scaler();
        t_store();
        t_bit();
        t_flow();
        conclude();
    end
endmodule

// ==== verilog/dcd_core_datapath.sv ====
`timescale 1ns/1ps
`include "dcd_params.svh"

// What this block does
// - Input scaler shifts a 16-bit word left 0 to 16 into 32 bits.
// - Input scaling is combinational, adding no cycle to any operation.
// - Multiplier forms a full 32-bit product in one cycle.
// - Each multiply picks signed or unsigned operation.
// - Micro store saves next fetch address during sequential data moves.
// - Next-address register holds the address for next bus cycle.
// - Output scaler shifts the accumulator left 0 to 7 places.
// - Output scaler writes upper or lower half to the write bus.
// - Current-address register holds bus address until the cycle ends.
// - Program counter increments next address for fetches and data moves.
// - Controller decodes ops, holds status, evaluates branch conditions.
// - Product register captures every multiply result.
// - Product scaler applies none, left 1, left 4 or right 6.
// - Hardware stack holds eight 16-bit return addresses or data words.
// - Temporary register supplies one multiply operand.
// - Temporary register gives shift count for shift-by-temp ops.
// - Temporary register gives the bit position for bit test.
// - Accumulator is a 32-bit register feeding later arithmetic.

module dcd_core_datapath (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire dcd_pkg::dcd_op_t op_i,
    input wire logic [15:0] data_i,
    input wire logic [4:0] in_shift_i,
    input wire dcd_pkg::dcd_product_scaler_t product_scaler_i,
    input wire logic [2:0] out_shift_i,
    input wire logic out_high_i,
    input wire dcd_pkg::dcd_flow_t flow_i,
    input wire dcd_pkg::dcd_cond_t cond_i,
    input wire logic [15:0] target_i,
    input wire logic [15:0] push_data_i,
    input wire logic bus_ready_i,
    output logic [31:0] acc_o,
    output logic [31:0] prod_o,
    output logic [15:0] multiply_operand_reg_o,
    output logic [15:0] program_address_bus_o,
    output logic [15:0] next_addr_o,
    output logic [15:0] data_write_bus_o,
    output logic dwb_valid_o,
    output logic bit_result_o,
    output logic bit_valid_o,
    output logic [15:0] stack_top_o,
    output logic [3:0] stack_depth_o,
    output logic data_move_o,
    output logic acc_zero_o,
    output logic acc_neg_o,
    output logic ovf_o
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] accumulator_reg;
        logic [31:0] product_reg;
        logic [15:0] multiply_operand_reg;
        logic [15:0] next_fetch_address_reg;
        logic [15:0] current_fetch_address_reg;
        logic [15:0] micro_return_store;
        logic data_move;
        logic ovf;
        logic [15:0] dwb;
        logic dwb_vld;
        logic bit_res;
        logic bit_vld;
    } dcd_core_st_t;

    dcd_core_st_t s_q;
    dcd_core_st_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Counts above the maximum clamp rather than wrap
    function automatic logic [31:0] input_scaler(input logic [15:0] d,
                                                 input logic [4:0] n);
        logic [4:0] k;
        k = (n > `DCD_ISHIFT_MAX) ? `DCD_ISHIFT_MAX : n;
        return {16'h0000, d} << k;
    endfunction

    // Result in [31:0], signed overflow in [32]
    function automatic logic [32:0] add_sub(input logic [31:0] a,
                                            input logic [31:0] b,
                                            input logic sub);
        logic [31:0] bb;
        logic [31:0] r;
        logic v;
        bb = sub ? ~b : b;
        r = a + bb + {31'h0000_0000, sub};
        v = (a[31] == bb[31]) && (r[31] != a[31]);
        return {v, r};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational datapath

    logic [31:0] mul_p;
    logic mul_signed;
    logic [4:0] in_cnt;
    logic [31:0] in_scaled;
    logic [31:0] p_scaled;
    logic [31:0] o_shifted;
    logic [15:0] pc_inc;
    logic [15:0] stk_top;
    logic [3:0] stk_depth;
    logic stk_push;
    logic stk_pop;
    logic [15:0] stk_push_data;
    logic cond_true;
    logic [32:0] arith;
    logic by_temp;

    assign mul_signed = (op_i == dcd_pkg::OP_MUL_SIGNED);

    dcd_mult u_mult (
        .a_i(s_q.multiply_operand_reg),
        .b_i(data_i),
        .signed_i(mul_signed),
        .prod_o(mul_p)
    );

    assign by_temp = (op_i == dcd_pkg::OP_LOAD_SHIFTED_BY_TEMP)
        || (op_i == dcd_pkg::OP_ADD_SHIFTED_BY_TEMP)
        || (op_i == dcd_pkg::OP_SUB_SHIFTED_BY_TEMP);

    assign in_cnt = by_temp ? {1'b0, s_q.multiply_operand_reg[3:0]}
                            : in_shift_i;

    assign in_scaled = input_scaler(data_i, in_cnt);

    always_comb begin
        case (product_scaler_i)
            dcd_pkg::PRODUCT_SCALER_NONE: begin
                p_scaled = s_q.product_reg;
            end
            dcd_pkg::PRODUCT_SCALER_LEFT1: begin
                p_scaled = s_q.product_reg << `DCD_PSHIFT_L1;
            end
            dcd_pkg::PRODUCT_SCALER_LEFT4: begin
                p_scaled = s_q.product_reg << `DCD_PSHIFT_L4;
            end
            dcd_pkg::PRODUCT_SCALER_RIGHT6: begin
                // Sign copies keep the scaled product's sign intact
                p_scaled = $signed(s_q.product_reg) >>> `DCD_PSHIFT_R6;
            end
            default: begin
                p_scaled = s_q.product_reg;
            end
        endcase
    end

    assign o_shifted = s_q.accumulator_reg << out_shift_i;

    assign pc_inc = s_q.next_fetch_address_reg + 16'h0001;

    always_comb begin
        case (cond_i)
            dcd_pkg::COND_ALWAYS: begin
                cond_true = 1'b1;
            end
            dcd_pkg::COND_EQ: begin
                cond_true = (s_q.accumulator_reg == `DCD_RESET_WORD32);
            end
            dcd_pkg::COND_NEQ: begin
                cond_true = (s_q.accumulator_reg != `DCD_RESET_WORD32);
            end
            dcd_pkg::COND_LT: begin
                cond_true = s_q.accumulator_reg[31];
            end
            dcd_pkg::COND_GEQ: begin
                cond_true = !s_q.accumulator_reg[31];
            end
            dcd_pkg::COND_OVF: begin
                cond_true = s_q.ovf;
            end
            default: begin
                cond_true = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack

    // push on call or data push
    assign stk_push = bus_ready_i && ((flow_i == dcd_pkg::FLOW_CALL)
        || (flow_i == dcd_pkg::FLOW_PUSH));
    assign stk_pop = bus_ready_i && ((flow_i == dcd_pkg::FLOW_RETURN)
        || (flow_i == dcd_pkg::FLOW_POP));
    assign stk_push_data = (flow_i == dcd_pkg::FLOW_CALL) ? pc_inc
                                                          : push_data_i;

    dcd_ret_stack u_stack (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .push_i(stk_push),
        .pop_i(stk_pop),
        .push_data_i(stk_push_data),
        .top_o(stk_top),
        .depth_o(stk_depth)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        s_d.dwb_vld = 1'b0;
        s_d.bit_vld = 1'b0;
        arith = add_sub(s_q.accumulator_reg, in_scaled, 1'b0);

        case (op_i)
            dcd_pkg::OP_LOAD_SHIFTED,
            dcd_pkg::OP_LOAD_SHIFTED_BY_TEMP: begin
                s_d.accumulator_reg = in_scaled;
            end
            dcd_pkg::OP_ADD_SHIFTED,
            dcd_pkg::OP_ADD_SHIFTED_BY_TEMP: begin
                arith = add_sub(s_q.accumulator_reg, in_scaled, 1'b0);
                s_d.accumulator_reg = arith[31:0];
                s_d.ovf = s_q.ovf | arith[32];
            end
            dcd_pkg::OP_SUB_SHIFTED,
            dcd_pkg::OP_SUB_SHIFTED_BY_TEMP: begin
                arith = add_sub(s_q.accumulator_reg, in_scaled, 1'b1);
                s_d.accumulator_reg = arith[31:0];
                s_d.ovf = s_q.ovf | arith[32];
            end
            dcd_pkg::OP_LOAD_TEMP: begin
                s_d.multiply_operand_reg = data_i;
            end
            dcd_pkg::OP_MUL_SIGNED,
            dcd_pkg::OP_MUL_UNSIGNED: begin
                s_d.product_reg = mul_p;
            end
            dcd_pkg::OP_LOAD_PROD: begin
                s_d.accumulator_reg = p_scaled;
            end
            dcd_pkg::OP_ADD_PROD: begin
                arith = add_sub(s_q.accumulator_reg, p_scaled, 1'b0);
                s_d.accumulator_reg = arith[31:0];
                s_d.ovf = s_q.ovf | arith[32];
            end
            dcd_pkg::OP_SUB_PROD: begin
                arith = add_sub(s_q.accumulator_reg, p_scaled, 1'b1);
                s_d.accumulator_reg = arith[31:0];
                s_d.ovf = s_q.ovf | arith[32];
            end
            dcd_pkg::OP_TEST_BIT_BY_TEMP: begin
                s_d.bit_res = data_i[s_q.multiply_operand_reg[3:0]];
                s_d.bit_vld = 1'b1;
            end
            dcd_pkg::OP_STORE: begin
                s_d.dwb = out_high_i ? o_shifted[31:16] : o_shifted[15:0];
                s_d.dwb_vld = 1'b1;
            end
            default: begin
                s_d.dwb_vld = 1'b0;
            end
        endcase

        // Flow ops wait for the bus cycle so the address never moves early
        if (bus_ready_i) begin
            // bus address moves only at cycle end
            s_d.current_fetch_address_reg = s_q.next_fetch_address_reg;
            case (flow_i)
                dcd_pkg::FLOW_SEQ,
                dcd_pkg::FLOW_PUSH,
                dcd_pkg::FLOW_POP: begin
                    s_d.next_fetch_address_reg = pc_inc;
                end
                dcd_pkg::FLOW_BRANCH,
                dcd_pkg::FLOW_CALL: begin
                    s_d.next_fetch_address_reg = target_i;
                end
                dcd_pkg::FLOW_BRANCH_COND: begin
                    s_d.next_fetch_address_reg = cond_true ? target_i
                                                           : pc_inc;
                end
                dcd_pkg::FLOW_RETURN: begin
                    s_d.next_fetch_address_reg = stk_top;
                end
                dcd_pkg::FLOW_DATA_MOVE_START: begin
                    s_d.micro_return_store = pc_inc;
                    s_d.data_move = 1'b1;
                    s_d.next_fetch_address_reg = target_i;
                end
                dcd_pkg::FLOW_DATA_MOVE_END: begin
                    s_d.next_fetch_address_reg = s_q.micro_return_store;
                    s_d.data_move = 1'b0;
                end
                default: begin
                    s_d.next_fetch_address_reg = pc_inc;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.next_fetch_address_reg <= `DCD_RESET_VECTOR;
            s_q.current_fetch_address_reg <= `DCD_RESET_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign acc_o = s_q.accumulator_reg;
    assign prod_o = s_q.product_reg;
    assign multiply_operand_reg_o = s_q.multiply_operand_reg;
    assign program_address_bus_o = s_q.current_fetch_address_reg;
    assign next_addr_o = s_q.next_fetch_address_reg;
    assign data_write_bus_o = s_q.dwb;
    assign dwb_valid_o = s_q.dwb_vld;
    assign bit_result_o = s_q.bit_res;
    assign bit_valid_o = s_q.bit_vld;
    assign stack_top_o = stk_top;
    assign stack_depth_o = stk_depth;
    assign data_move_o = s_q.data_move;
    assign acc_zero_o = (s_q.accumulator_reg == `DCD_RESET_WORD32);
    assign acc_neg_o = s_q.accumulator_reg[31];
    assign ovf_o = s_q.ovf;

endmodule

// ==== verilog/dcd_mult.sv ====
`timescale 1ns/1ps

module dcd_mult (
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic signed_i,
    output logic [31:0] prod_o
);

    logic signed [16:0] a_ext;
    logic signed [16:0] b_ext;
    logic signed [33:0] full;

    // Extend by one bit so one signed multiplier serves both modes
    assign a_ext = {a_i[15] & signed_i, a_i};
    assign b_ext = {b_i[15] & signed_i, b_i};
    assign full = a_ext * b_ext;
    assign prod_o = full[31:0];

endmodule

// ==== verilog/dcd_params.svh ====
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH

// Scaler limits and fixed shift amounts
`define DCD_ISHIFT_MAX 5'h10
`define DCD_OSHIFT_MAX 3'h7
`define DCD_PSHIFT_L1 1
`define DCD_PSHIFT_L4 4
`define DCD_PSHIFT_R6 6

// Return stack geometry
`define DCD_STACK_DEPTH 4'h8
`define DCD_STACK_PTR_W 3

// Reset values
`define DCD_RESET_VECTOR 16'h0000
`define DCD_RESET_WORD16 16'h0000
`define DCD_RESET_WORD32 32'h0000_0000

`endif

// ==== verilog/dcd_pkg.sv ====
package dcd_pkg;

    // Arithmetic and scaler operations, one per cycle
    typedef enum logic [3:0] {
        OP_NOP,
        OP_LOAD_SHIFTED,
        OP_ADD_SHIFTED,
        OP_SUB_SHIFTED,
        OP_LOAD_SHIFTED_BY_TEMP,
        OP_ADD_SHIFTED_BY_TEMP,
        OP_SUB_SHIFTED_BY_TEMP,
        OP_LOAD_TEMP,
        OP_MUL_SIGNED,
        OP_MUL_UNSIGNED,
        OP_LOAD_PROD,
        OP_ADD_PROD,
        OP_SUB_PROD,
        OP_TEST_BIT_BY_TEMP,
        OP_STORE
    } dcd_op_t;

    // Program flow operations, taken with bus_ready_i
    typedef enum logic [3:0] {
        FLOW_SEQ,
        FLOW_BRANCH,
        FLOW_BRANCH_COND,
        FLOW_CALL,
        FLOW_RETURN,
        FLOW_DATA_MOVE_START,
        FLOW_DATA_MOVE_END,
        FLOW_PUSH,
        FLOW_POP
    } dcd_flow_t;

    typedef enum logic [2:0] {
        COND_ALWAYS,
        COND_EQ,
        COND_NEQ,
        COND_LT,
        COND_GEQ,
        COND_OVF
    } dcd_cond_t;

    typedef enum logic [1:0] {
        PRODUCT_SCALER_NONE,
        PRODUCT_SCALER_LEFT1,
        PRODUCT_SCALER_LEFT4,
        PRODUCT_SCALER_RIGHT6
    } dcd_product_scaler_t;

endpackage

// ==== verilog/dcd_ret_stack.sv ====
`timescale 1ns/1ps
`include "dcd_params.svh"

module dcd_ret_stack (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [15:0] push_data_i,
    output logic [15:0] top_o,
    output logic [3:0] depth_o
);

    typedef struct packed {
        logic [7:0][15:0] mem;
        logic [`DCD_STACK_PTR_W-1:0] ptr;
        logic [3:0] cnt;
    } dcd_stk_st_t;

    dcd_stk_st_t s_q;
    dcd_stk_st_t s_d;

    // Circular store: a push on a full stack drops the deepest entry
    always_comb begin
        s_d = s_q;
        if (push_i) begin
            s_d.mem[s_q.ptr] = push_data_i;
            s_d.ptr = s_q.ptr + 3'h1;
            if (s_q.cnt != `DCD_STACK_DEPTH) begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end else if (pop_i && (s_q.cnt != 4'h0)) begin
            s_d.ptr = s_q.ptr - 3'h1;
            s_d.cnt = s_q.cnt - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign top_o = s_q.mem[s_q.ptr - 3'h1];
    assign depth_o = s_q.cnt;

endmodule
